// ### hdl/tx_operating_mode_sequencer.sv
`timescale 1ns/1ns
`include "tx_sequencer_consts.svh"
module tx_operating_mode_sequencer #(
    parameter int ENLOW_CYCLES = `ENLOW_CYCLES,
    parameter int BAUD_DIV     = `BAUD_DIV_DEFAULT
) (
    // Clock and power-on reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pins from outside, asynchronous
    input  wire logic enPin,
    input  wire logic sckPin,
    input  wire logic sdioIn,
    input  wire logic vregLowIn,
    // Serial data pins
    output logic      sdioOut,
    output logic      sdioOe,
    output logic      sdoOut,
    output logic      sdoOe,
    output logic      ckOut,
    // Analog controls
    output logic      synthPower,
    output logic      xoEnable,
    output logic      xoRegulated,
    output logic      modData,
    output tx_seq_pkg::pa_ctrl_s paCtrl,
    output tx_seq_pkg::mode_e    modeState
);
    import tx_seq_pkg::*;

    localparam logic [19:0] LOW_LIM    = 20'(ENLOW_CYCLES);
    localparam logic [19:0] LOW_LIM_M1 = 20'(ENLOW_CYCLES - 1);

    seq_state_s r_reg;
    seq_state_s r_next;
    logic [3:0] syncV;
    logic       baudTick;
    logic       baudClk;

    // Decoded events of the current cycle
    logic       enS;
    logic       sckS;
    logic       sdioS;
    logic       vregLowS;
    logic       enRise;
    logic       enFall;
    logic       sckRise;
    logic       sckFall;
    logic       longLow;
    logic       spiOn;
    logic [7:0] byteIn;
    logic       regWr;
    logic [5:0] wrAddr;
    logic [7:0] wrData;
    logic       txWr;
    logic       sleepReq;
    logic       txCmd;

    // Register read mux, unmapped addresses read as zero
    function automatic logic [7:0] readReg(input regs_s rg, input logic [5:0] a);
        case (a)
            `ADDR_AMP0:  readReg = rg.amp0;
            `ADDR_AMP1:  readReg = rg.amp1;
            `ADDR_AMP2:  readReg = rg.amp2;
            `ADDR_RAMP:  readReg = rg.ramp;
            `ADDR_TXCTL: readReg = rg.txctl;
            default:     readReg = 8'h00;
        endcase
    endfunction

    // Stage pattern: low level when data high and ASK enabled, else chosen high level
    function automatic logic [3:0] ampSelect(input regs_s rg, input logic hiSel,
                                             input logic dat);
        logic askOn;
        logic [3:0] hiLvl;
        askOn = hiSel ? rg.amp1[`BIT_ASK_SELECT] : rg.amp0[`BIT_ASK_SELECT];
        hiLvl = hiSel ? rg.amp1[3:0] : rg.amp0[3:0];
        ampSelect = (dat && askOn) ? rg.amp2[3:0] : hiLvl;
    endfunction

    pin_sync #(.WIDTH(4)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .asyncIn ({vregLowIn, sdioIn, sckPin, enPin}),
        .syncOut (syncV)
    );

    baud_gen #(.DIV(BAUD_DIV)) u_baud (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .restart (r_reg.baudRestart),
        .run     (r_reg.paActive),
        .tick    (baudTick),
        .baudClk (baudClk)
    );

    // Next state of the whole sequencer
    always_comb begin
        r_next   = r_reg;
        enS      = syncV[0];
        sckS     = syncV[1];
        sdioS    = syncV[2];
        vregLowS = syncV[3];
        enRise   = enS && !r_reg.enPrev;
        enFall   = !enS && r_reg.enPrev;
        sckRise  = sckS && !r_reg.sckPrev;
        sckFall  = !sckS && r_reg.sckPrev;
        byteIn   = {r_reg.shiftIn[6:0], sdioS};
        regWr    = 1'b0;
        wrAddr   = r_reg.addr;
        wrData   = byteIn;
        txCmd    = 1'b0;
        r_next.enPrev      = enS;
        r_next.sckPrev     = sckS;
        r_next.baudRestart = 1'b0;

        // Only an unbroken low period reaches the limit
        if (enS) begin
            r_next.enLowCnt = '0;
        end else if (r_reg.enLowCnt != LOW_LIM) begin
            r_next.enLowCnt = r_reg.enLowCnt + 20'h00001;
        end
        longLow = !enS && (r_reg.enLowCnt == LOW_LIM_M1);

        // Serial port is deaf in power-down and while data streams
        spiOn = (r_reg.mode != MODE_PD) && !r_reg.streaming;
        if (enRise) begin
            r_next.bitCnt = 3'h0;
            r_next.phase  = PH_CMD;
        end else if (spiOn && sckRise) begin
            r_next.shiftIn = byteIn;
            r_next.bitCnt  = r_reg.bitCnt + 3'h1;
            if (r_reg.bitCnt == 3'h7) begin
                case (r_reg.phase)
                    PH_CMD: begin
                        r_next.addr = byteIn[5:0];
                        case (byteIn[7:6])
                            `OP_WRITE: r_next.phase = PH_WR;
                            `OP_READ: begin
                                r_next.phase    = PH_RD;
                                r_next.shiftOut = readReg(r_reg.regs, byteIn[5:0]);
                            end
                            `OP_TRANSMIT: txCmd = 1'b1;
                            default: r_next.addr = r_reg.addr;
                        endcase
                    end
                    PH_WR: begin
                        regWr       = 1'b1;
                        r_next.addr = r_reg.addr + 6'h01;
                    end
                    PH_RD: begin
                        r_next.addr     = r_reg.addr + 6'h01;
                        r_next.shiftOut = readReg(r_reg.regs, r_reg.addr + 6'h01);
                    end
                    default: r_next.phase = PH_CMD;
                endcase
            end
        end else if (spiOn && sckFall && r_reg.phase == PH_RD && r_reg.bitCnt != 3'h0) begin
            r_next.shiftOut = {r_reg.shiftOut[6:0], 1'b0};
        end

        // Register writes; reserved bits 6:4 of AMP0 and AMP1 read back as zero
        txWr     = regWr && (wrAddr == `ADDR_TXCTL);
        sleepReq = txWr && wrData[`BIT_SLEEP_REQ];
        if (regWr) begin
            case (wrAddr)
                `ADDR_AMP0:  r_next.regs.amp0  = wrData & `AMP_WRITE_MASK;
                `ADDR_AMP1:  r_next.regs.amp1  = wrData & `AMP_WRITE_MASK;
                `ADDR_AMP2:  r_next.regs.amp2  = wrData;
                `ADDR_RAMP:  r_next.regs.ramp  = wrData;
                `ADDR_TXCTL: r_next.regs.txctl = wrData;
                default:     r_next.regs = r_reg.regs;
            endcase
        end

        // Stream data from the data pin, one bit per baud period
        if (r_reg.mode == MODE_TX && r_reg.streaming && baudTick) begin
            r_next.modData = sdioS;
        end

        // Mode transitions
        case (r_reg.mode)
            MODE_PD: begin
                if (enRise) begin
                    r_next.mode = MODE_XO;
                    r_next.regs.txctl[`BIT_SLEEP_REQ] = 1'b0;
                end
            end
            MODE_XO: begin
                if (txWr && wrData[`BIT_SYNTH_POWER]) begin
                    r_next.mode = MODE_SYN;
                end
            end
            MODE_SYN: begin
                if (txWr && !wrData[`BIT_SYNTH_POWER]) begin
                    r_next.mode = MODE_XO;
                end else if (txCmd && r_reg.regs.txctl[`BIT_SYNTH_POWER]) begin
                    r_next.mode        = MODE_TX;
                    r_next.streaming   = 1'b1;
                    r_next.txOpts      = byteIn[2:0];
                    r_next.paActive    = 1'b1;
                    r_next.baudRestart = 1'b1;
                end
            end
            MODE_TX: begin
                if (vregLowS) begin
                    r_next.regs.txctl[`BIT_SYNTH_POWER] = 1'b0;
                    r_next.mode = MODE_XO;
                end else if (txWr && !wrData[`BIT_SYNTH_POWER]) begin
                    r_next.mode = MODE_XO;
                end else if (txCmd) begin
                    // Resume without touching the baud timer keeps its phase
                    r_next.streaming = 1'b1;
                    r_next.txOpts    = byteIn[2:0];
                end else if (r_reg.streaming && enFall) begin
                    if (r_reg.txOpts[`OPT_LOOP_ON_EN]) begin
                        r_next.modData   = sdioS;
                        r_next.streaming = 1'b0;
                    end else if (r_reg.txOpts[`OPT_SYNC_EXIT]) begin
                        r_next.exitPending = 1'b1;
                    end else begin
                        r_next.mode = MODE_SYN;
                    end
                end else if (r_reg.exitPending && baudTick) begin
                    r_next.mode = MODE_SYN;
                end
            end
            default: r_next.mode = MODE_PD;
        endcase

        // Sleep request wins over all transitions but the long low
        if (sleepReq && r_reg.mode != MODE_PD) begin
            r_next.mode = MODE_PD;
        end
        if (longLow) begin
            r_next.mode   = MODE_PD;
            r_next.regs.txctl[`BIT_SYNTH_POWER] = 1'b0;
            r_next.bitCnt = 3'h0;
            r_next.phase  = PH_CMD;
        end
        if (r_next.mode != MODE_TX) begin
            r_next.streaming   = 1'b0;
            r_next.paActive    = 1'b0;
            r_next.exitPending = 1'b0;
        end

        // Registered outputs follow the next state
        r_next.synthPower  = (r_next.mode == MODE_SYN) || (r_next.mode == MODE_TX);
        r_next.xoEnable    = (r_next.mode != MODE_PD);
        r_next.xoRegulated = r_next.regs.txctl[`BIT_XO_REG_SUPPLY]
                             && (r_next.mode == MODE_TX);
        r_next.pa.enable   = r_next.paActive;
        r_next.pa.level    = r_next.regs.txctl[`BIT_PA_LEVEL_HI:`BIT_PA_LEVEL_LO];
        r_next.pa.stages   = r_next.paActive ? ampSelect(r_next.regs,
                             r_next.txOpts[`OPT_AMP_HIGH_SEL], r_next.modData) : 4'h0;
        r_next.ckOut       = r_next.paActive && baudClk;
        r_next.sdioOut     = r_next.shiftOut[7];
        r_next.sdoOut      = r_next.shiftOut[7];
        r_next.sdioOe      = (r_next.mode != MODE_PD) && !r_next.streaming
                             && (r_next.phase == PH_RD) && !r_next.regs.amp2[`BIT_SDO_ENABLE];
        r_next.sdoOe       = (r_next.mode != MODE_PD) && !r_next.streaming
                             && (r_next.phase == PH_RD) && r_next.regs.amp2[`BIT_SDO_ENABLE];
    end

    // State register; power-on reset lands in power-down
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.mode  <= MODE_PD;
            r_reg.phase <= PH_CMD;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sdioOut     = r_reg.sdioOut;
    assign sdioOe      = r_reg.sdioOe;
    assign sdoOut      = r_reg.sdoOut;
    assign sdoOe       = r_reg.sdoOe;
    assign ckOut       = r_reg.ckOut;
    assign synthPower  = r_reg.synthPower;
    assign xoEnable    = r_reg.xoEnable;
    assign xoRegulated = r_reg.xoRegulated;
    assign modData     = r_reg.modData;
    assign paCtrl      = r_reg.pa;
    assign modeState   = r_reg.mode;

    // Checks on the mode sequence
    property p_long_low;
        @(posedge clk_sys) disable iff (!rst_n)
        longLow |=> (r_reg.mode == MODE_PD) && !sdioOe && !sdoOe && !xoEnable;
    endproperty
    a_long_low: assert property (p_long_low) else $error("Long low did not power down");

    property p_long_low_synth;
        @(posedge clk_sys) disable iff (!rst_n)
        longLow |=> !r_reg.regs.txctl[`BIT_SYNTH_POWER] && !synthPower;
    endproperty
    a_long_low_synth: assert property (p_long_low_synth) else $error("Synth bit kept");

    property p_sleep;
        @(posedge clk_sys) disable iff (!rst_n)
        sleepReq && (r_reg.mode != MODE_PD) |=> (r_reg.mode == MODE_PD) ##1 !xoEnable;
    endproperty
    a_sleep: assert property (p_sleep) else $error("Sleep request ignored");

    property p_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        (r_reg.mode == MODE_PD) && enRise |=>
            (r_reg.mode == MODE_XO) && !r_reg.regs.txctl[`BIT_SLEEP_REQ] && xoEnable;
    endproperty
    a_wake: assert property (p_wake) else $error("Enable rise did not wake");

    property p_synth_on;
        @(posedge clk_sys) disable iff (!rst_n)
        (r_reg.mode == MODE_XO) && txWr && wrData[`BIT_SYNTH_POWER]
            && !wrData[`BIT_SLEEP_REQ] && !longLow |=> (r_reg.mode == MODE_SYN) && synthPower;
    endproperty
    a_synth_on: assert property (p_synth_on) else $error("Synth did not power");

    property p_synth_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (r_reg.mode == MODE_SYN) && txWr && !wrData[`BIT_SYNTH_POWER]
            && !wrData[`BIT_SLEEP_REQ] && !longLow |=> (r_reg.mode == MODE_XO) && !synthPower;
    endproperty
    a_synth_off: assert property (p_synth_off) else $error("Synth did not stop");

    property p_tx_entry;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(r_reg.mode == MODE_TX) |->
            $past(r_reg.regs.txctl[`BIT_SYNTH_POWER]) && $past(txCmd) && r_reg.baudRestart;
    endproperty
    a_tx_entry: assert property (p_tx_entry) else $error("Illegal transmit entry");

    property p_brownout;
        @(posedge clk_sys) disable iff (!rst_n)
        (r_reg.mode == MODE_TX) && vregLowS && !longLow && !sleepReq |=>
            (r_reg.mode == MODE_XO) && !r_reg.regs.txctl[`BIT_SYNTH_POWER] && !paCtrl.enable;
    endproperty
    a_brownout: assert property (p_brownout) else $error("Brown-out not handled");

    property p_hold_data;
        @(posedge clk_sys) disable iff (!rst_n)
        (r_reg.mode == MODE_TX) && !r_reg.streaming ##1 (r_reg.mode == MODE_TX)
            |-> $stable(modData);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("Held data changed");

    property p_xo_reg;
        @(posedge clk_sys) disable iff (!rst_n)
        xoRegulated |-> (r_reg.mode == MODE_TX) && r_reg.regs.txctl[`BIT_XO_REG_SUPPLY];
    endproperty
    a_xo_reg: assert property (p_xo_reg) else $error("Regulated supply outside transmit");

    property p_low_count;
        @(posedge clk_sys) disable iff (!rst_n)
        enS |=> (r_reg.enLowCnt == 20'h00000);
    endproperty
    a_low_count: assert property (p_low_count) else $error("Low counter not cleared");

    c_long_low: cover property (@(posedge clk_sys) disable iff (!rst_n) longLow);
    c_tx_entry: cover property (@(posedge clk_sys) disable iff (!rst_n)
                                $rose(r_reg.mode == MODE_TX));
    c_loop_hold: cover property (@(posedge clk_sys) disable iff (!rst_n)
                                 (r_reg.mode == MODE_TX) && $fell(r_reg.streaming));
    c_brownout: cover property (@(posedge clk_sys) disable iff (!rst_n)
                                (r_reg.mode == MODE_TX) && vregLowS);
endmodule

// ### hdl/tx_sequencer_consts.svh
`ifndef TX_SEQUENCER_CONSTS_SVH
`define TX_SEQUENCER_CONSTS_SVH

// Register addresses on the serial port (six address bits)
`define ADDR_AMP0          6'h0A
`define ADDR_AMP1          6'h0B
`define ADDR_AMP2          6'h0C
`define ADDR_RAMP          6'h0D
`define ADDR_TXCTL         6'h0E

// Field positions in the transmitter control register
`define BIT_SYNTH_POWER    0
`define BIT_XO_REG_SUPPLY  1
`define BIT_PA_LEVEL_LO    2
`define BIT_PA_LEVEL_HI    3
`define BIT_SLEEP_REQ      7

// Field positions in the amplitude registers
`define BIT_ASK_SELECT     7
`define BIT_SDO_ENABLE     4
`define AMP_WRITE_MASK     8'h8F

// Reset value of every register
`define REG_RESET          8'h00

// Command opcodes (top two bits of the first byte)
`define OP_WRITE           2'h0
`define OP_READ            2'h1
`define OP_TRANSMIT        2'h2

// Option bits of the transmit command
`define OPT_AMP_HIGH_SEL   0
`define OPT_SYNC_EXIT      1
`define OPT_LOOP_ON_EN     2

// Timing counts in crystal clock cycles, and the low counter width in bits
`define ENLOW_CYCLES       65536
`define ENLOW_CNT_W        20
`define BAUD_DIV_DEFAULT   16

`endif

// ### hdl/tx_seq_pkg.sv
package tx_seq_pkg;

    // Operating modes, one-hot
    typedef enum logic [3:0] {
        MODE_PD  = 4'h1,
        MODE_XO  = 4'h2,
        MODE_SYN = 4'h4,
        MODE_TX  = 4'h8
    } mode_e;

    // Serial frame phase, one-hot
    typedef enum logic [2:0] {
        PH_CMD = 3'h1,
        PH_WR  = 3'h2,
        PH_RD  = 3'h4
    } phase_e;

    // Register set
    typedef struct packed {
        logic [7:0] amp0;
        logic [7:0] amp1;
        logic [7:0] amp2;
        logic [7:0] ramp;
        logic [7:0] txctl;
    } regs_s;

    // Power amplifier controls
    typedef struct packed {
        logic       enable;
        logic [1:0] level;
        logic [3:0] stages;
    } pa_ctrl_s;

    // Whole state of the sequencer
    typedef struct packed {
        mode_e      mode;
        phase_e     phase;
        logic [2:0] bitCnt;
        logic [5:0] addr;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        regs_s      regs;
        logic [19:0] enLowCnt;
        logic       enPrev;
        logic       sckPrev;
        logic       streaming;
        logic       paActive;
        logic       exitPending;
        logic [2:0] txOpts;
        logic       modData;
        logic       baudRestart;
        logic       synthPower;
        logic       xoEnable;
        logic       xoRegulated;
        logic       sdioOut;
        logic       sdioOe;
        logic       sdoOut;
        logic       sdoOe;
        logic       ckOut;
        pa_ctrl_s   pa;
    } seq_state_s;

endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Pins
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s syncReg;
    sync_s syncNext;

    // First stage feeds only the second stage
    always_comb begin
        syncNext        = syncReg;
        syncNext.stage1 = asyncIn;
        syncNext.stage2 = syncReg.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            syncReg <= '0;
        end else begin
            syncReg <= syncNext;
        end
    end

    assign syncOut = syncReg.stage2;
endmodule

// ### hdl/baud_gen.sv
`timescale 1ns/1ns
module baud_gen #(
    parameter int DIV = 16
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic restart,
    input  wire logic run,
    // Baud outputs
    output logic      tick,
    output logic      baudClk
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         clk;
        logic         tick;
    } baud_s;

    baud_s baudReg;
    baud_s baudNext;

    // Half period of DIV cycles; holding while stopped keeps the phase
    always_comb begin
        baudNext      = baudReg;
        baudNext.tick = 1'b0;
        if (restart) begin
            baudNext.cnt = '0;
            baudNext.clk = 1'b0;
        end else if (run) begin
            if (baudReg.cnt == LAST) begin
                baudNext.cnt  = '0;
                baudNext.clk  = ~baudReg.clk;
                baudNext.tick = baudReg.clk; // New bit on falling baud edge
            end else begin
                baudNext.cnt = baudReg.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            baudReg <= '0;
        end else begin
            baudReg <= baudNext;
        end
    end

    assign tick    = baudReg.tick;
    assign baudClk = baudReg.clk;
endmodule

// ### testbench/host_model.sv
`timescale 1ns/1ns
`include "tx_sequencer_consts.svh"
module host_model (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      enPin,
    output logic      sckPin,
    output logic      sdioDrv,
    input  wire logic sdioWire
);
    logic [7:0] rdByte;
    initial begin
        enPin   = 1'b0;
        sckPin  = 1'b0;
        sdioDrv = 1'b0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Short low then rise starts a frame, far below the long-low limit
    task automatic frameStart();
        enPin <= 1'b0;
        waitClk(6);
        enPin <= 1'b1;
        waitClk(6);
    endtask
    // One byte, MSB first; six clocks a level so the synchroniser keeps up
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            sdioDrv <= tx[i];
            waitClk(5);
            @(negedge clk_sys);
            rdByte[i] = sdioWire;
            @(posedge clk_sys);
            sckPin <= 1'b1;
            waitClk(6);
            sckPin <= 1'b0;
        end
        sdioDrv <= ~tx[0]; // Released line shows no stale level
        waitClk(6);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        frameStart();
        xfer({`OP_WRITE, a});
        xfer(d);
    endtask
    task automatic rd(input logic [5:0] a);
        frameStart();
        xfer({`OP_READ, a});
        xfer(8'h00);
    endtask
    task automatic txCmd(input logic [5:0] opt);
        frameStart();
        xfer({`OP_TRANSMIT, opt});
    endtask
endmodule

// ### testbench/tb_tx_operating_mode_sequencer.sv
`timescale 1ns/1ns
`include "tx_sequencer_consts.svh"
module tb_tx_operating_mode_sequencer;
    import tx_seq_pkg::*;
    logic clk_sys, rst_n, enPin, sckPin, sdioIn, sdioDrv, vregLowIn;
    logic sdioOut, sdioOe, sdoOut, sdoOe, ckOut;
    logic synthPower, xoEnable, xoRegulated, modData;
    pa_ctrl_s paCtrl;
    mode_e modeState;
    int errors, tests_run;
    logic ckSeen;
    // Shared data wire: device wins while reading in three-wire mode (SDO enable clear)
    assign sdioIn = sdioOe ? sdioOut : sdioDrv;
    tx_operating_mode_sequencer #(.ENLOW_CYCLES(64), .BAUD_DIV(2))
        tx_operating_mode_sequencer_i (.clk_sys, .rst_n, .enPin, .sckPin,
        .sdioIn, .vregLowIn, .sdioOut, .sdioOe, .sdoOut, .sdoOe, .ckOut,
        .synthPower, .xoEnable, .xoRegulated, .modData, .paCtrl, .modeState);
    host_model host_model_i (.clk_sys, .enPin, .sckPin, .sdioDrv,
        .sdioWire(sdioIn));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Sample away from the edge, then realign to a rising edge
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        @(negedge clk_sys);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
        @(posedge clk_sys);
    endtask
    task automatic chkMode(input mode_e e);
        host_model_i.waitClk(6);
        chk("mode", 8'(e), 8'(modeState));
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        vregLowIn = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        chkMode(MODE_PD);
        host_model_i.frameStart();
        chkMode(MODE_XO);
        chk("xo", 8'h01, 8'(xoEnable));
        host_model_i.wr(`ADDR_TXCTL, 8'h01);
        chkMode(MODE_SYN);
        host_model_i.rd(`ADDR_TXCTL);
        chk("rd", 8'h01, host_model_i.rdByte);
        host_model_i.wr(`ADDR_TXCTL, 8'h00);
        chkMode(MODE_XO);
        host_model_i.txCmd(6'h00);
        chkMode(MODE_XO);
        host_model_i.wr(`ADDR_AMP0, 8'h05);
        host_model_i.wr(`ADDR_TXCTL, 8'h0F);
        host_model_i.txCmd(6'h00);
        chkMode(MODE_TX);
        chk("pa", 8'h75, 8'({paCtrl.enable, paCtrl.level, paCtrl.stages}));
        chk("xoReg", 8'h01, 8'(xoRegulated));
        // Baud clock out toggles every BAUD_DIV cycles while the amplifier runs
        @(negedge clk_sys);
        ckSeen = ckOut;
        repeat (2) @(negedge clk_sys);
        chk("ck", 8'(!ckSeen), 8'(ckOut));
        host_model_i.enPin <= 1'b0;
        chkMode(MODE_SYN);
        chk("xoReg", 8'h00, 8'(xoRegulated));
        host_model_i.txCmd(6'h04);
        // Latch a low level; the command bits that follow must not reach the modulator
        host_model_i.sdioDrv <= 1'b0;
        host_model_i.frameStart();
        host_model_i.xfer({`OP_WRITE, `ADDR_TXCTL});
        chk("hold", 8'h00, 8'(modData));
        host_model_i.xfer(8'h0C);
        chkMode(MODE_XO);
        host_model_i.wr(`ADDR_TXCTL, 8'h01);
        host_model_i.txCmd(6'h00);
        vregLowIn <= 1'b1;
        chkMode(MODE_XO);
        vregLowIn <= 1'b0;
        host_model_i.rd(`ADDR_TXCTL);
        chk("brown", 8'h00, host_model_i.rdByte);
        host_model_i.wr(`ADDR_TXCTL, 8'h81);
        chkMode(MODE_PD);
        host_model_i.rd(`ADDR_TXCTL);
        chk("sleep", 8'h01, host_model_i.rdByte);
        host_model_i.wr(`ADDR_TXCTL, 8'h01);
        chkMode(MODE_SYN);
        host_model_i.enPin <= 1'b0;
        host_model_i.waitClk(40);
        host_model_i.enPin <= 1'b1;
        chkMode(MODE_SYN);
        host_model_i.enPin <= 1'b0;
        host_model_i.waitClk(80);
        chkMode(MODE_PD);
        chk("oe", 8'h00, 8'({synthPower, sdioOe}));
        host_model_i.frameStart();
        host_model_i.rd(`ADDR_TXCTL);
        chk("synth", 8'h00, host_model_i.rdByte);
        // Four-wire read: data leaves on the separate output, next register follows
        host_model_i.wr(`ADDR_RAMP, 8'h80);
        host_model_i.wr(`ADDR_AMP2, 8'h10);
        host_model_i.rd(`ADDR_AMP2);
        chk("sdo", 8'h05, 8'({sdoOe, sdioOe, sdoOut}));
        test_done();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        test_done();
    end
endmodule
